// ===== core/clk_switch_pkg.sv
// Purpose: Constants and types for the CPU clock source switch
// Assumes: One 100 MHz system clock, all inputs except the async reset_i synchronous
// Notes:   Switch delays are counted in system clock cycles
package clk_switch_pkg;

   localparam int CLK_PERIOD_NS      = 10;
   // Delay before a written selection takes effect
   localparam int MAIN_SWITCH_NS     = 20;
   localparam int CPU_SWITCH_NS      = 30;
   localparam int MAIN_SWITCH_CYC    = (MAIN_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CPU_SWITCH_CYC     = (CPU_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W              = 4;

   localparam logic CPU_SEL_RST      = 1'b0;
   localparam logic MAIN_SEL_RST     = 1'b0;
   localparam logic FAST_STOP_RST    = 1'b0;
   localparam logic MAIN_STOP_RST    = 1'b1;
   localparam logic SUB_STOP_RST     = 1'b1;

   // Active CPU source, one-hot
   typedef enum logic [4:0] {
      SRC_FAST_INT = 5'b0_0001,
      SRC_MAIN_XTAL = 5'b0_0010,
      SRC_MAIN_EXT = 5'b0_0100,
      SRC_SUB_XTAL = 5'b0_1000,
      SRC_SUB_EXT  = 5'b1_0000
   } src_type;

   typedef struct packed {
      logic main_osc_mode_select;
      logic main_external_input_select;
      logic main_source_stop;
      logic sub_osc_mode_select;
      logic sub_external_input_select;
      logic sub_source_stop;
      logic internal_fast_osc_stop;
      logic cpu_source_select;
      logic main_source_select;
   } ctrl_type;

   typedef struct packed {
      logic fast_int_run;
      logic main_xtal_run;
      logic main_ext_valid;
      logic sub_xtal_run;
      logic sub_ext_valid;
   } osc_en_type;

endpackage

// ===== core/cpu_clock_source_switch.sv
// Purpose: Tracks and switches the CPU clock source, gates oscillators
// Assumes: Software keeps the pre-switch conditions; inputs other than the async reset_i synchronous
// Notes:   Illegal direct moves leave the source unchanged and flag it
//          The taken target is latched until the switch ends
`timescale 1ns/1ps
module cpu_clock_source_switch
   import clk_switch_pkg::*;
(
   input  wire logic       clk_sys_i,      // System clock
   input  wire logic       reset_i,        // Async reset, high
   input  wire logic       clk_en_i,       // Freeze all state when low
   input  wire ctrl_type   ctrl_i,         // Software control bits
   output logic            cpu_source_status_o,  // 1: CPU on sub source
   output logic            main_source_status_o, // 1: main is system clock
   output src_type         active_src_o,   // Source driving CPU
   output osc_en_type      osc_en_o,       // Oscillator enables / input valid
   output logic            switch_busy_o,  // Switch pending
   output logic            illegal_move_o  // Last request was illegal
);

   // Switch state
   src_type            src_ff;         // CPU source now in use
   src_type            nxt_src;
   src_type            pend_ff;        // Source a running switch ends on
   src_type            nxt_pend;
   logic               cpu_stat_ff;
   logic               nxt_cpu_stat;
   logic               main_stat_ff;
   logic               nxt_main_stat;
   logic [CNT_W-1:0]   cnt_ff;
   logic [CNT_W-1:0]   nxt_cnt;
   logic               busy_ff;
   logic               nxt_busy;
   logic               illegal_ff;
   logic               nxt_illegal;

   // Oscillator state
   osc_en_type         osc_ff;
   osc_en_type         nxt_osc;

   // Decoded request
   src_type            target;
   logic               cpu_move;
   logic               main_swap;
   logic               sub_swap;
   logic               swap_req;
   logic               start_req;
   logic               switch_done;
   logic               pend_on_sub;
   logic               pend_on_sys;

   // Per-source gating terms
   logic               main_xtal_mode;
   logic               main_ext_mode;
   logic               sub_xtal_mode;
   logic               sub_ext_mode;
   logic               fast_idle;
   logic               main_xtal_idle;
   logic               main_ext_idle;
   logic               sub_xtal_idle;
   logic               sub_ext_idle;

   // Requested source from selection and mode bits
   always_comb begin
      if (ctrl_i.cpu_source_select) begin
         target = ctrl_i.sub_external_input_select ? SRC_SUB_EXT : SRC_SUB_XTAL;
      end else if (ctrl_i.main_source_select) begin
         target = ctrl_i.main_external_input_select ? SRC_MAIN_EXT : SRC_MAIN_XTAL;
      end else begin
         target = SRC_FAST_INT;
      end
   end

   // Kind of move asked for
   always_comb begin
      cpu_move    = (ctrl_i.cpu_source_select != cpu_stat_ff);
      main_swap   = ((src_ff == SRC_MAIN_XTAL) && (target == SRC_MAIN_EXT)) ||
                    ((src_ff == SRC_MAIN_EXT) && (target == SRC_MAIN_XTAL));
      sub_swap    = ((src_ff == SRC_SUB_XTAL) && (target == SRC_SUB_EXT)) ||
                    ((src_ff == SRC_SUB_EXT) && (target == SRC_SUB_XTAL));
      swap_req    = main_swap || sub_swap;
      start_req   = !busy_ff && (target != src_ff) && !swap_req;
      switch_done = busy_ff && (cnt_ff == '0);
      pend_on_sub = (pend_ff == SRC_SUB_XTAL) || (pend_ff == SRC_SUB_EXT);
      pend_on_sys = (pend_ff == SRC_MAIN_XTAL) || (pend_ff == SRC_MAIN_EXT);
   end

   // Latched target: a write during the wait cannot turn the move into a swap
   always_comb begin
      nxt_src       = src_ff;
      nxt_pend      = pend_ff;
      nxt_cpu_stat  = cpu_stat_ff;
      nxt_main_stat = main_stat_ff;
      nxt_cnt       = cnt_ff;
      nxt_busy      = busy_ff;
      nxt_illegal   = illegal_ff;
      if (busy_ff) begin
         if (switch_done) begin
            nxt_busy = 1'b0;
            nxt_src  = pend_ff;
            nxt_cpu_stat = pend_on_sub;
            if (pend_on_sys) begin
               nxt_main_stat = 1'b1;
            end else if (pend_ff == SRC_FAST_INT) begin
               nxt_main_stat = 1'b0;
            end
         end else begin
            nxt_cnt = cnt_ff - CNT_W'(1);
         end
      end else if (swap_req) begin
         nxt_illegal = 1'b1;
      end else if (start_req) begin
         nxt_illegal = 1'b0;
         nxt_busy    = 1'b1;
         nxt_pend    = target;
         // Sub moves take the longer path through the CPU mux
         if (cpu_move) begin
            nxt_cnt = CNT_W'(CPU_SWITCH_CYC - 1);
         end else begin
            nxt_cnt = CNT_W'(MAIN_SWITCH_CYC - 1);
         end
      end
   end

   // Switch state registers
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         src_ff       <= SRC_FAST_INT;
         pend_ff      <= SRC_FAST_INT;
         cpu_stat_ff  <= CPU_SEL_RST;
         main_stat_ff <= MAIN_SEL_RST;
         cnt_ff       <= '0;
         busy_ff      <= 1'b0;
         illegal_ff   <= 1'b0;
      end else if (clk_en_i) begin
         src_ff       <= nxt_src;
         pend_ff      <= nxt_pend;
         cpu_stat_ff  <= nxt_cpu_stat;
         main_stat_ff <= nxt_main_stat;
         cnt_ff       <= nxt_cnt;
         busy_ff      <= nxt_busy;
         illegal_ff   <= nxt_illegal;
      end
   end

   // Mode bits say which input each pin pair carries
   always_comb begin
      main_xtal_mode = ctrl_i.main_osc_mode_select && !ctrl_i.main_external_input_select;
      main_ext_mode  = ctrl_i.main_osc_mode_select && ctrl_i.main_external_input_select;
      sub_xtal_mode  = ctrl_i.sub_osc_mode_select && !ctrl_i.sub_external_input_select;
      sub_ext_mode   = ctrl_i.sub_osc_mode_select && ctrl_i.sub_external_input_select;
   end

   // Idle means the CPU is not running from that source
   always_comb begin
      fast_idle      = (src_ff != SRC_FAST_INT);
      main_xtal_idle = (src_ff != SRC_MAIN_XTAL);
      main_ext_idle  = (src_ff != SRC_MAIN_EXT);
      sub_xtal_idle  = (src_ff != SRC_SUB_XTAL);
      sub_ext_idle   = (src_ff != SRC_SUB_EXT);
   end

   // Oscillator enables; a stop bit never stops the active source
   always_comb begin
      nxt_osc.fast_int_run   = !(ctrl_i.internal_fast_osc_stop && fast_idle);
      nxt_osc.main_xtal_run  = main_xtal_mode &&
                               !(ctrl_i.main_source_stop && main_xtal_idle);
      nxt_osc.main_ext_valid = main_ext_mode &&
                               !(ctrl_i.main_source_stop && main_ext_idle);
      nxt_osc.sub_xtal_run   = sub_xtal_mode &&
                               !(ctrl_i.sub_source_stop && sub_xtal_idle);
      nxt_osc.sub_ext_valid  = sub_ext_mode &&
                               !(ctrl_i.sub_source_stop && sub_ext_idle);
   end

   // Oscillator registers; stop bits only gate idle sources
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         osc_ff.fast_int_run   <= ~FAST_STOP_RST;
         osc_ff.main_xtal_run  <= ~MAIN_STOP_RST;
         osc_ff.main_ext_valid <= ~MAIN_STOP_RST;
         osc_ff.sub_xtal_run   <= ~SUB_STOP_RST;
         osc_ff.sub_ext_valid  <= ~SUB_STOP_RST;
      end else if (clk_en_i) begin
         osc_ff <= nxt_osc;
      end
   end

   // Outputs straight from flops

   assign cpu_source_status_o  = cpu_stat_ff;
   assign main_source_status_o = main_stat_ff;
   assign active_src_o         = src_ff;
   assign osc_en_o             = osc_ff;
   assign switch_busy_o        = busy_ff;
   assign illegal_move_o       = illegal_ff;

endmodule // cpu_clock_source_switch

// ===== sim/cpu_clock_source_switch_assertions.sv
// Purpose: Port checks for the CPU clock source switch
// Assumes: clk_en_i dropped only while no switch is pending
// Notes:   Busy lasts 2 or 3 cycles
`timescale 1ns/1ps
module cpu_clock_source_switch_assertions
   import clk_switch_pkg::*;
(
   input wire logic       clk_sys_i,            // Clock
   input wire logic       reset_i,              // Reset
   input wire logic       clk_en_i,             // Enable
   input wire ctrl_type   ctrl_i,               // Controls
   input wire logic       cpu_source_status_o,  // On sub
   input wire logic       main_source_status_o, // Main is system
   input wire src_type    active_src_o,         // Source
   input wire osc_en_type osc_en_o,             // Enables
   input wire logic       switch_busy_o,        // Busy
   input wire logic       illegal_move_o        // Illegal
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   wire logic on_sub = active_src_o inside {SRC_SUB_XTAL, SRC_SUB_EXT};
   wire logic on_main = active_src_o inside {SRC_MAIN_XTAL, SRC_MAIN_EXT};
   sequence s_done; ##[2:3] $fell(switch_busy_o); endsequence
   // Quiet in the same cycle, so the source cannot move under the stop
   sequence s_quiet; !switch_busy_o; endsequence
   a_busy_len: assert property ($rose(switch_busy_o) |-> s_done) else $error("busy length");
   a_src_moves: assert property ($changed(active_src_o) |-> $past(switch_busy_o) && !switch_busy_o)
      else $error("source moved early");
   a_cpu_status: assert property (cpu_source_status_o == on_sub) else $error("cpu status");
   a_main_status: assert property (!on_sub |-> main_source_status_o == on_main) else $error("main status");
   a_fast_stop: assert property (ctrl_i.internal_fast_osc_stop && active_src_o != SRC_FAST_INT ##0 s_quiet
      |=> !osc_en_o.fast_int_run) else $error("fast runs");
   a_main_stop: assert property (ctrl_i.main_source_stop && !on_main ##0 s_quiet
      |=> !osc_en_o.main_xtal_run && !osc_en_o.main_ext_valid) else $error("main runs");
   a_sub_stop: assert property (ctrl_i.sub_source_stop && !on_sub ##0 s_quiet
      |=> !osc_en_o.sub_xtal_run && !osc_en_o.sub_ext_valid) else $error("sub runs");
   a_illegal_hold: assert property ($rose(illegal_move_o) |-> !switch_busy_o && $stable(active_src_o))
      else $error("illegal moved");
endmodule // cpu_clock_source_switch_assertions
bind cpu_clock_source_switch cpu_clock_source_switch_assertions u_chk (.clk_sys_i, .reset_i, .clk_en_i, .ctrl_i,
   .cpu_source_status_o, .main_source_status_o, .active_src_o, .osc_en_o, .switch_busy_o, .illegal_move_o);

// ===== sim/cpu_clock_source_switch_tb_top.sv
// Purpose: Walks the clock switch through its moves
// Assumes: Controls change at the falling edge
// Notes:   Control words are msb-first ctrl_type values
`timescale 1ns/1ps
module cpu_clock_source_switch_tb_top
   import clk_switch_pkg::*;
;
   logic       clk_sys_i;
   logic       reset_i;
   logic       clk_en_i;
   ctrl_type   ctrl_i;
   logic       cpu_source_status_o;
   logic       main_source_status_o;
   src_type    active_src_o;
   osc_en_type osc_en_o;
   logic       switch_busy_o;
   logic       illegal_move_o;
   int         errors;
   int         comparisons;
   cpu_clock_source_switch uut (.clk_sys_i, .reset_i, .clk_en_i, .ctrl_i, .cpu_source_status_o,
      .main_source_status_o, .active_src_o, .osc_en_o, .switch_busy_o, .illegal_move_o);
   task automatic close_out();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [4:0] got, input logic [4:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Enables settle one cycle after a control write
   task automatic settle(input logic [8:0] c, input logic [4:0] e);
      @(negedge clk_sys_i);
      ctrl_i = c;
      repeat (2) @(negedge clk_sys_i);
      check(osc_en_o, e);
   endtask
   task automatic move(input logic [8:0] c, input src_type s, input int n);
      int w;
      int k;
      @(negedge clk_sys_i);
      ctrl_i = c;
      w = 0;
      k = 0;
      while (switch_busy_o !== 1'b1 && w < 4) begin
         @(negedge clk_sys_i);
         w++;
      end
      while (switch_busy_o === 1'b1 && k < 8) begin
         @(negedge clk_sys_i);
         k++;
      end
      if (w == 4 || k == 8) begin
         errors++;
         close_out();
      end
      check(5'(k), 5'(n));
      check(active_src_o, s);
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      errors = 0;
      comparisons = 0;
      reset_i = 1'b1;
      clk_en_i = 1'b1;
      ctrl_i = 9'h048;
      repeat (12) @(negedge clk_sys_i);
      reset_i = 1'b0;
      settle(9'h048, 5'h10);
      move(9'h109, SRC_MAIN_XTAL, 2);
      check(5'(main_source_status_o), 5'h01);
      settle(9'h10D, 5'h08);
      settle(9'h18D, 5'h04);
      check(5'(illegal_move_o), 5'h01);
      move(9'h127, SRC_SUB_XTAL, 3);
      check(5'({cpu_source_status_o, illegal_move_o}), 5'h02);
      settle(9'h167, 5'h02);
      move(9'h125, SRC_MAIN_XTAL, 3);
      settle(9'h12D, 5'h08);
      move(9'h128, SRC_FAST_INT, 2);
      settle(9'h168, 5'h10);
      move(9'h1A9, SRC_MAIN_EXT, 2);
      move(9'h1B3, SRC_SUB_EXT, 3);
      settle(9'h1F3, 5'h11);
      move(9'h1B1, SRC_MAIN_EXT, 3);
      settle(9'h1B9, 5'h14);
      move(9'h1A8, SRC_FAST_INT, 2);
      check(5'(main_source_status_o), 5'h00);
      settle(9'h024, 5'h12);
      // Enable low: a request must not be taken
      @(negedge clk_sys_i);
      clk_en_i = 1'b0;
      ctrl_i = 9'h022;
      repeat (4) @(negedge clk_sys_i);
      check(5'(switch_busy_o), 5'h00);
      check(active_src_o, SRC_FAST_INT);
      clk_en_i = 1'b1;
      move(9'h022, SRC_SUB_XTAL, 3);
      settle(9'h026, 5'h02);
      move(9'h020, SRC_FAST_INT, 3);
      check(5'({cpu_source_status_o, main_source_status_o}), 5'h00);
      close_out();
   end
endmodule // cpu_clock_source_switch_tb_top
